// >>> dv/ssams_rx.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------
// receiver model on one serial line
// ------------------------------------
module ssams_rx (
  input  wire logic       clk,
  input  wire logic       line,
  input  wire logic [7:0] div,
  input  wire logic [3:0] nbits,
  input  wire logic [1:0] par,
  output logic      [7:0] rx_byte,
  output logic            rx_stb,
  output logic            rx_err
);
  logic       prev;
  logic       e;
  logic       p;
  logic [7:0] d;
  initial
  begin
    rx_stb = 1'b0;
    rx_err = 1'b0;
    rx_byte = 8'h00;
    prev = 1'b1;
    forever
    begin
      @(posedge clk);
      rx_stb <= 1'b0;
      if (prev && !line)
      begin
        repeat (div / 2) @(posedge clk);
        e = line;
        d = 8'h00;
        for (int i = 0; i < nbits; i++)
        begin
          repeat (div) @(posedge clk);
          d[i] = line;
        end
        p = ^d;
        if (par != 2'h0)
        begin
          repeat (div) @(posedge clk);
          e = e | (p ^ line ^ (par == 2'h2));
        end
        repeat (div) @(posedge clk);
        rx_byte <= d;
        rx_err  <= e | !line;
        rx_stb  <= 1'b1;
      end
      prev = line;
    end
  end
endmodule
`default_nettype wire

// >>> dv/ssams_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------
// port checker
// ------------------------------------
module ssams_top_sva #(
  parameter int MSG_PERIOD = 2000
)(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       self_test_done,
  input  wire logic       serial_out_one,
  input  wire logic       serial_out_two,
  input  wire logic       serial_out_three,
  input  wire logic       serial_out_four,
  input  wire logic       serial_out_five,
  input  wire logic [1:0] grp_busy
);
  logic busy_d_ff;
  logic seen_ff;
  int   cnt_ff;
  logic busy_rise;
  assign busy_rise = grp_busy[0] && !busy_d_ff;
  // cycles since last message start; first start after reset has no reference
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_d_ff <= 1'b0;
      seen_ff   <= 1'b0;
      cnt_ff    <= 0;
    end
    else
    begin
      busy_d_ff <= grp_busy[0];
      seen_ff   <= seen_ff | busy_rise;
      cnt_ff    <= busy_rise ? 1 : cnt_ff + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_lead;
    serial_out_one ##1 serial_out_one;
  endsequence
  sequence s_start;
    !serial_out_one ##1 !serial_out_one;
  endsequence
  a_test_gate: assert property (!self_test_done |-> grp_busy == 2'h0 && serial_out_one)
    else $error("line active before self-test done");
  a_first_start: assert property ($rose(self_test_done) |-> s_lead ##[1:3] !serial_out_one)
    else $error("first start bit not on time");
  a_idle_a: assert property (!grp_busy[0] |-> serial_out_one)
    else $error("group a line low while idle");
  a_idle_b: assert property (!grp_busy[1] |-> serial_out_four)
    else $error("group b line low while idle");
  a_group_a_same: assert property (serial_out_one == serial_out_two && serial_out_two == serial_out_three)
    else $error("group a lines differ");
  a_group_b_same: assert property (serial_out_four == serial_out_five)
    else $error("group b lines differ");
  // shortest bit is two cycles at the bench divisors
  a_start_min: assert property ($fell(serial_out_one) |-> s_start)
    else $error("low bit shorter than a bit time");
  a_period_exact: assert property (busy_rise && seen_ff |-> cnt_ff == MSG_PERIOD)
    else $error("message period wrong");
  c_group_b: cover property ($rose(grp_busy[1]));
endmodule
bind ssams_top ssams_top_sva #(.MSG_PERIOD(MSG_PERIOD)) chk_u (
  .clk(clk), .rst(rst), .self_test_done(self_test_done),
  .serial_out_one(serial_out_one), .serial_out_two(serial_out_two),
  .serial_out_three(serial_out_three), .serial_out_four(serial_out_four),
  .serial_out_five(serial_out_five), .grp_busy(grp_busy));
`default_nettype wire

// >>> dv/ssams_top_test.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------
// testbench
// ------------------------------------
module ssams_top_test
  import ssams_pkg::*;
;
  localparam int MP  = 2000;
  localparam int D12 = 8;
  localparam int D24 = 4;
  localparam int D96 = 2;
  // straps a b res, sw a, sw b, sw fine, digitizer
  localparam logic [8:0] TV [11] = '{9'h1C1, 9'h18D, 9'h141, 9'h140, 9'h0C1, 9'h0C0,
                                     9'h041, 9'h1D5, 9'h1E9, 9'h1F3, 9'h14D};
  logic               clk, rst, sa, sb, rn, swr, std, dg;
  logic        [1:0]  swa, swb, busy;
  logic signed [17:0] alt;
  logic signed [15:0] altm;
  logic signed [7:0]  tmp;
  logic        [15:0] cks;
  logic               o1, o2, o3, o4, o5, st_a, st_b, er_a, er_b;
  logic        [7:0]  div_a, div_b, by_a, by_b;
  logic        [3:0]  nb_a, nb_b;
  logic        [1:0]  pa_a, pa_b;
  logic        [8:0]  qa[$], qb[$];
  logic        [7:0]  ea[$], eb[$];
  int                 miscompares, total_checks, cyc;

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ssams_top #(.MSG_PERIOD(MP), .DIV_1200(D12), .DIV_2400(D24), .DIV_9600(D96),
    .FIFO_D(FIFO_DEPTH)) dut_u (.clk(clk), .rst(rst), .strap_fmt_a_n(sa),
    .strap_fmt_b_n(sb), .strap_res_n(rn), .sw_fmt_grp_a(swa), .sw_fmt_grp_b(swb),
    .sw_res_fine(swr), .self_test_done(std), .digitizer_on(dg), .altitude_ft(alt),
    .altitude_m(altm), .temp_c(tmp), .checksum_ascii(cks), .serial_out_one(o1),
    .serial_out_two(o2), .serial_out_three(o3), .serial_out_four(o4),
    .serial_out_five(o5), .grp_busy(busy));
  ssams_rx rx_a (.clk(clk), .line(o1), .div(div_a), .nbits(nb_a), .par(pa_a),
    .rx_byte(by_a), .rx_stb(st_a), .rx_err(er_a));
  ssams_rx rx_b (.clk(clk), .line(o4), .div(div_b), .nbits(nb_b), .par(pa_b),
    .rx_byte(by_b), .rx_stb(st_b), .rx_err(er_b));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // format code: 0 hash-AL, 1 ALT fast, 2 ALT slow, 3 MGL, 4 metric, 5 odd, 6 one-foot
  function automatic int fmt(input logic g);
    logic [1:0] c;
    c = g ? swb : swa;
    if (!sa && !sb) return 3;
    if (!sb) return 1;
    if (!sa) return 2;
    case (c)
      2'h1: return 4;
      2'h2: return 5;
      2'h3: return g ? 6 : 0;
      default: return 0;
    endcase
  endfunction

  function automatic logic [13:0] frm(input int f);
    logic [7:0] d;
    d = (f == 1 || f == 4 || f == 6) ? 8'(D96) : ((f == 2) ? 8'(D24) : 8'(D12));
    return {d, (f == 3 || f == 5) ? 4'h7 : 4'h8, (f == 3) ? 2'h1 : ((f == 5) ? 2'h2 : 2'h0)};
  endfunction

  task automatic build(input int f, ref logic [7:0] q[$]);
    int    st, m;
    string s, sg, ts, ck, d;
    st = (f == 6) ? 1 : ((!rn || swr) ? 10 : 100);
    m = (((alt < 0) ? -int'(alt) : int'(alt)) / st * st) % 100000;
    sg = (alt < 0) ? "-" : "+";
    ts = (tmp < 0) ? "-" : "+";
    ck = $sformatf("%c%c", cks[15:8], cks[7:0]);
    d = $sformatf("%05d", m);
    case (f)
      0: s = {"#AL ", sg, d, "T", ts, $sformatf("%02d", ((tmp < 0) ? -int'(tmp) : int'(tmp)) % 100), ck, "\r"};
      1, 2:
      begin
        if (!dg) d = (f == 1) ? "-9900" : "-2500";
        else if (alt < 0) d = $sformatf("-%04d", m % 10000);
        s = {"ALT ", d, "\r"};
      end
      3: s = {"$MGL", sg, d, "T+25", ck, "\r"};
      4: s = {$sformatf("%c$PASHS,ALT,+%05d*", CH_STX, int'(altm)), ck, "\r\n", $sformatf("%c", CH_ETX)};
      5: s = {"#AL ", sg, d, "T+25", ck, "\r"};
      default: s = {"RMS ", sg, d, "T", ts, "55", ck, "\r"};
    endcase
    q = {};
    foreach (s[i]) q.push_back(s[i]);
  endtask

  task automatic do_reset();
    std <= 1'b0;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // random straps and fields while self-test runs: nothing may leave the lines
  task automatic idle_test();
    repeat (40)
    begin
      @(posedge clk);
      check(busy, 2'h0);
      check({o1, o2, o3}, 3'h7);
      check({o4, o5}, 2'h3);
      {sa, sb, rn, swa, swb, swr, dg} <= 9'($urandom);
      alt <= 18'($urandom);
    end
    check(qa.size() + qb.size(), 0);
    $display("idle test done");
  endtask

  task automatic run(input int t);
    int n;
    {sa, sb, rn, swa, swb, swr, dg} <= TV[t];
    alt <= 18'($urandom_range(43000)) - 18'h003E8;
    altm <= 16'($urandom_range(120) * 100);
    tmp <= 8'($urandom_range(120)) - 8'h37;
    cks <= {8'h41 + 8'($urandom_range(5)), 8'h30 + 8'($urandom_range(9))};
    do_reset();
    build(fmt(1'b0), ea);
    build(fmt(1'b1), eb);
    {div_a, nb_a, pa_a} <= frm(fmt(1'b0));
    {div_b, nb_b, pa_b} <= frm(fmt(1'b1));
    qa = {};
    qb = {};
    std <= 1'b1;
    for (n = 0; n < 3 * MP && (qa.size() < 2 * ea.size() || qb.size() < eb.size()); n++)
      @(posedge clk);
    check(qa.size(), 2 * ea.size());
    check(qb.size() >= eb.size(), 1'b1);
    foreach (ea[i])
    begin
      check(qa[i], {1'b0, ea[i]});
      check(qa[i + ea.size()], {1'b0, ea[i]});
    end
    foreach (eb[i])
      check(qb[i], {1'b0, eb[i]});
    $display("test %0d done", t);
  endtask

  always @(posedge clk)
  begin
    if (st_a === 1'b1) qa.push_back({er_a, by_a});
    if (st_b === 1'b1) qb.push_back({er_b, by_b});
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      miscompares++;
      summarize();
    end
  end

  initial
  begin
    rst = 1'b1;
    std = 1'b0;
    {sa, sb, rn, swa, swb, swr, dg} = 9'h1C1;
    {alt, altm, tmp, cks} = '0;
    {div_a, nb_a, pa_a, div_b, nb_b, pa_b} = '0;
    miscompares = 0;
    total_checks = 0;
    void'($urandom(93));
    do_reset();
    idle_test();
    for (int t = 0; t < 11; t++)
      run(t);
    summarize();
  end
endmodule
`default_nettype wire

// >>> hdl/ssams_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module ssams_fifo
  import ssams_pkg::*;
#(
  parameter int WIDTH = BYTE_W,
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;
  logic             push;
  logic             pop;

  // extra pointer bit tells full from empty
  assign in_ready  = !((wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                       (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]));
  assign out_valid = (wr_ptr_ff != rd_ptr_ff);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/ssams_pkg.sv
// Behaviour
// - altitude in 100-foot steps by default
// - grounded resolution strap selects 10-foot steps
// - each output repeats message twice per second
// - bit rate 1200 to 9600, set by format
// - start/stop framing, default 1200 8N1
// - transmit only, never wait for receiver
// - straps open: 17-byte hash-AL message, 1200 8N1
// - second strap grounded: ten-byte ALT, 9600 8N1
// - 9600 ALT disabled digitizer sends -9900
// - first strap grounded: ten-byte ALT, 2400 8N1
// - 2400 ALT disabled digitizer sends -2500
// - both grounded: dollar-MGL message, 1200 7E1
// - software metric: 24-byte PASHS, 9600 8N1
// - software odd variant: hash-AL, 1200 7O1
// - software one-foot: RMS message, 9600 8N1
// - one-foot message only on outputs four, five
// - two output groups, format chosen per group
// - sending starts only after self-test done
package ssams_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int MSG_PERIOD_MS = 500;
  localparam int MSG_PERIOD_CYC = (CLK_HZ / 1000) * MSG_PERIOD_MS;
  localparam int BAUD_1200     = 1200;
  localparam int BAUD_2400     = 2400;
  localparam int BAUD_9600     = 9600;
  localparam int DIV_1200_CYC  = CLK_HZ / BAUD_1200;
  localparam int DIV_2400_CYC  = CLK_HZ / BAUD_2400;
  localparam int DIV_9600_CYC  = CLK_HZ / BAUD_9600;
  localparam int DIV_W         = 17;

  // ----------------------------------------
  // resolution and message sizes
  // ----------------------------------------
  localparam logic [16:0] RES_COARSE_FT = 17'h00064;
  localparam logic [16:0] RES_FINE_FT   = 17'h0000A;
  localparam logic [16:0] RES_ONE_FT    = 17'h00001;
  localparam logic [4:0]  LEN_LONG      = 5'h11;
  localparam logic [4:0]  LEN_SHORT     = 5'h0A;
  localparam logic [4:0]  LEN_METRIC    = 5'h18;
  localparam int          MSG_MAX_BYTES = 24;
  localparam int          FIFO_DEPTH    = 8;
  localparam int          BYTE_W        = 8;

  // ----------------------------------------
  // software format codes and reset values
  // ----------------------------------------
  localparam logic [1:0] SW_FMT_DEFAULT = 2'h0;
  localparam logic [1:0] SW_FMT_METRIC  = 2'h1;
  localparam logic [1:0] SW_FMT_ODD     = 2'h2;
  localparam logic [1:0] SW_FMT_ONEFOOT = 2'h3;
  localparam logic [2:0] STRAP_OPEN_RST = 3'h7;

  // ----------------------------------------
  // fixed message text
  // ----------------------------------------
  localparam logic [7:0]  CH_CR    = 8'h0D;
  localparam logic [7:0]  CH_LF    = 8'h0A;
  localparam logic [7:0]  CH_STX   = 8'h02;
  localparam logic [7:0]  CH_ETX   = 8'h03;
  localparam logic [7:0]  CH_PLUS  = 8'h2B;
  localparam logic [7:0]  CH_MINUS = 8'h2D;
  localparam logic [7:0]  CH_ZERO  = 8'h30;
  localparam logic [31:0] TXT_AL   = 32'h23414C20;
  localparam logic [31:0] TXT_ALT  = 32'h414C5420;
  localparam logic [31:0] TXT_MGL  = 32'h244D474C;
  localparam logic [31:0] TXT_RMS  = 32'h524D5320;
  localparam logic [31:0] TXT_T25  = 32'h542B3235;
  localparam logic [15:0] TXT_55   = 16'h3535;
  localparam logic [7:0]  TXT_T    = 8'h54;
  localparam logic [7:0]  TXT_STAR = 8'h2A;
  localparam logic [87:0] TXT_PASH = 88'h2450415348532C414C542C;
  localparam logic [39:0] TXT_DIS_9600 = 40'h2D39393030;
  localparam logic [39:0] TXT_DIS_2400 = 40'h2D32353030;

  typedef enum logic [2:0] {
    FMT_AL, FMT_ALT9600, FMT_ALT2400, FMT_MGL, FMT_PASHS, FMT_AL_ODD, FMT_RMS
  } ssams_fmt_t;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP
  } ssams_tx_t;

  // five zero-padded ASCII decimal digits, most significant first
  function automatic logic [39:0] to_ascii5(input logic [16:0] v);
    logic [39:0] r;
    logic [16:0] t;
    r = '0;
    t = v;
    for (int i = 0; i < 5; i++)
    begin
      r[8*i +: 8] = CH_ZERO + 8'(t % 17'h0000A);
      t = t / 17'h0000A;
    end
    return r;
  endfunction

endpackage

// >>> hdl/ssams_top.sv
`timescale 1ns/10ps
`default_nettype none
module ssams_top
  import ssams_pkg::*;
#(
  parameter int MSG_PERIOD = MSG_PERIOD_CYC,
  parameter int DIV_1200   = DIV_1200_CYC,
  parameter int DIV_2400   = DIV_2400_CYC,
  parameter int DIV_9600   = DIV_9600_CYC,
  parameter int FIFO_D     = FIFO_DEPTH
)(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               strap_fmt_a_n,
  input  wire logic               strap_fmt_b_n,
  input  wire logic               strap_res_n,
  input  wire logic [1:0]         sw_fmt_grp_a,
  input  wire logic [1:0]         sw_fmt_grp_b,
  input  wire logic               sw_res_fine,
  input  wire logic               self_test_done,
  input  wire logic               digitizer_on,
  input  wire logic signed [17:0] altitude_ft,
  input  wire logic signed [15:0] altitude_m,
  input  wire logic signed [7:0]  temp_c,
  input  wire logic [15:0]        checksum_ascii,
  output logic                    serial_out_one,
  output logic                    serial_out_two,
  output logic                    serial_out_three,
  output logic                    serial_out_four,
  output logic                    serial_out_five,
  output logic [1:0]              grp_busy
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [4:0] fmt_len(input ssams_fmt_t f);
    case (f)
      FMT_ALT9600, FMT_ALT2400: fmt_len = LEN_SHORT;
      FMT_PASHS:                fmt_len = LEN_METRIC;
      default:                  fmt_len = LEN_LONG;
    endcase
  endfunction

  function automatic logic [DIV_W-1:0] fmt_div(input ssams_fmt_t f);
    case (f)
      FMT_ALT9600, FMT_PASHS, FMT_RMS: fmt_div = DIV_W'(DIV_9600);
      FMT_ALT2400:                     fmt_div = DIV_W'(DIV_2400);
      default:                         fmt_div = DIV_W'(DIV_1200);
    endcase
  endfunction

  // ----------------------------------------
  // strap synchronisers
  // ----------------------------------------
  logic [2:0] strap_s1_ff;
  logic [2:0] strap_s2_ff;
  logic [2:0] strap_s3_ff;
  logic [2:0] strap_ff;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      strap_s1_ff <= STRAP_OPEN_RST;
      strap_s2_ff <= STRAP_OPEN_RST;
      strap_s3_ff <= STRAP_OPEN_RST;
      strap_ff    <= STRAP_OPEN_RST;
    end
    else
    begin
      strap_s1_ff <= {strap_res_n, strap_fmt_b_n, strap_fmt_a_n};
      strap_s2_ff <= strap_s1_ff;
      strap_s3_ff <= strap_s2_ff;
      for (int i = 0; i < 3; i++)
        if (strap_s2_ff[i] == strap_s3_ff[i])
          strap_ff[i] <= strap_s3_ff[i];
    end
  end

  // ----------------------------------------
  // message period
  // ----------------------------------------
  logic [31:0] per_cnt_ff;
  logic        msg_tick;

  assign msg_tick = self_test_done && (per_cnt_ff == '0);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      per_cnt_ff <= '0;
    else if (!self_test_done)
      per_cnt_ff <= '0;
    else if (per_cnt_ff == 32'(MSG_PERIOD - 1))
      per_cnt_ff <= '0;
    else
      per_cnt_ff <= per_cnt_ff + 32'h00000001;
  end

  // ----------------------------------------
  // message fields shared by both groups
  // ----------------------------------------
  logic [16:0]  mag_ft;
  logic [16:0]  mag_m;
  logic [6:0]   mag_t;
  logic [7:0]   sgn_ft;
  logic [7:0]   sgn_m;
  logic [7:0]   sgn_t;
  logic [16:0]  res_std;
  logic [39:0]  dig_std;
  logic [39:0]  dig_one;
  logic [39:0]  dig_m;
  logic [15:0]  dig_t;
  logic [39:0]  dig_tmp;
  logic [39:0]  alt5;

  assign mag_ft = altitude_ft[17] ? 17'(-altitude_ft) : altitude_ft[16:0];
  assign mag_m  = altitude_m[15]  ? {1'b0, 16'(-altitude_m)} : {1'b0, altitude_m};
  assign mag_t  = temp_c[7] ? 7'(-temp_c) : temp_c[6:0];
  assign sgn_ft = altitude_ft[17] ? CH_MINUS : CH_PLUS;
  assign sgn_m  = altitude_m[15]  ? CH_MINUS : CH_PLUS;
  assign sgn_t  = temp_c[7]       ? CH_MINUS : CH_PLUS;

  assign res_std = (!strap_ff[2] || sw_res_fine) ? RES_FINE_FT : RES_COARSE_FT;
  assign dig_std = to_ascii5(17'((mag_ft / res_std) * res_std));
  assign dig_one = to_ascii5(mag_ft / RES_ONE_FT);
  assign dig_m   = to_ascii5(mag_m);
  assign dig_tmp = to_ascii5({10'h000, mag_t});
  assign dig_t   = dig_tmp[15:0];
  // short form: a minus sign takes the leading digit place
  assign alt5    = altitude_ft[17] ? {CH_MINUS, dig_std[31:0]} : dig_std;

  // ----------------------------------------
  // output groups: 0 drives one..three, 1 drives four, five
  // ----------------------------------------
  logic [1:0] grp_line;

  for (genvar g = 0; g < 2; g++)
  begin : grp
    ssams_fmt_t        fmt_sel;
    ssams_fmt_t        fmt_ff;
    logic [1:0]        sw_fmt;
    logic [191:0]      msg_now;
    logic [191:0]      msg_ff;
    logic [4:0]        rem_ff;
    logic              load_busy;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic              fifo_out_ready;
    logic [7:0]        fifo_out_data;
    logic              active;
    ssams_tx_t         tx_st_ff;
    logic [DIV_W-1:0]  div_cnt_ff;
    logic              bit_en;
    logic [2:0]        bit_ff;
    logic [7:0]        shreg_ff;
    logic              par_ff;
    logic              line_ff;
    logic              seven_bit;
    logic              has_par;

    assign sw_fmt = (g == 0) ? sw_fmt_grp_a : sw_fmt_grp_b;

    // software choice only with straps open
    always_comb
    begin
      case ({strap_ff[0], strap_ff[1]})
        2'h2:    fmt_sel = FMT_ALT9600;
        2'h1:    fmt_sel = FMT_ALT2400;
        2'h0:    fmt_sel = FMT_MGL;
        default:
        begin
          case (sw_fmt)
            SW_FMT_METRIC:  fmt_sel = FMT_PASHS;
            SW_FMT_ODD:     fmt_sel = FMT_AL_ODD;
            SW_FMT_ONEFOOT: fmt_sel = (g == 1) ? FMT_RMS : FMT_AL;
            default:        fmt_sel = FMT_AL;
          endcase
        end
      endcase
    end

    // message text, left aligned in the buffer
    always_comb
    begin
      case (fmt_sel)
        FMT_AL:
          msg_now = {TXT_AL, sgn_ft, dig_std, TXT_T, sgn_t, dig_t,
                     checksum_ascii, CH_CR, 56'h0};
        FMT_AL_ODD:
          msg_now = {TXT_AL, sgn_ft, dig_std, TXT_T25, checksum_ascii, CH_CR, 56'h0};
        FMT_ALT9600:
          msg_now = {TXT_ALT, digitizer_on ? alt5 : TXT_DIS_9600, CH_CR, 112'h0};
        FMT_ALT2400:
          msg_now = {TXT_ALT, digitizer_on ? alt5 : TXT_DIS_2400, CH_CR, 112'h0};
        FMT_MGL:
          msg_now = {TXT_MGL, sgn_ft, dig_std, TXT_T25, checksum_ascii, CH_CR, 56'h0};
        FMT_PASHS:
          msg_now = {CH_STX, TXT_PASH, sgn_m, dig_m, TXT_STAR, checksum_ascii,
                     CH_CR, CH_LF, CH_ETX};
        FMT_RMS:
          msg_now = {TXT_RMS, sgn_ft, dig_one, TXT_T, sgn_t, TXT_55,
                     checksum_ascii, CH_CR, 56'h0};
        default:
          msg_now = '0;
      endcase
    end

    // a tick that comes before the last message has fully left the line loads nothing
    assign load_busy = (rem_ff != '0);
    assign active    = load_busy || fifo_out_valid || (tx_st_ff != TX_IDLE);

    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        fmt_ff <= FMT_AL;
        msg_ff <= '0;
        rem_ff <= '0;
      end
      else if (msg_tick && !active)
      begin
        fmt_ff <= fmt_sel;
        msg_ff <= msg_now;
        rem_ff <= fmt_len(fmt_sel);
      end
      else if (load_busy && fifo_in_ready)
      begin
        msg_ff <= {msg_ff[183:0], 8'h00};
        rem_ff <= rem_ff - 5'h01;
      end
    end

    ssams_fifo #(
      .WIDTH (BYTE_W),
      .DEPTH (FIFO_D)
    ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (load_busy),
      .in_ready  (fifo_in_ready),
      .in_data   (msg_ff[191:184]),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
    );

    assign bit_en = (tx_st_ff != TX_IDLE) && (div_cnt_ff == fmt_div(fmt_ff) - 1'b1);

    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        div_cnt_ff <= '0;
      else if (tx_st_ff == TX_IDLE || bit_en)
        div_cnt_ff <= '0;
      else
        div_cnt_ff <= div_cnt_ff + 1'b1;
    end

    assign seven_bit      = (fmt_ff == FMT_MGL) || (fmt_ff == FMT_AL_ODD);
    assign has_par        = seven_bit;
    assign fifo_out_ready = (tx_st_ff == TX_IDLE);

    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        tx_st_ff <= TX_IDLE;
        bit_ff   <= '0;
        shreg_ff <= '0;
        par_ff   <= 1'b0;
        line_ff  <= 1'b1;
      end
      else
      begin
        case (tx_st_ff)
          TX_IDLE:
            if (fifo_out_valid)
            begin
              shreg_ff <= fifo_out_data;
              // even for the 1200 7E1 form, odd for the 7O1 form
              par_ff   <= (^fifo_out_data[6:0]) ^ (fmt_ff == FMT_AL_ODD);
              line_ff  <= 1'b0;
              tx_st_ff <= TX_START;
            end
          TX_START:
            if (bit_en)
            begin
              line_ff  <= shreg_ff[0];
              shreg_ff <= {1'b0, shreg_ff[7:1]};
              bit_ff   <= '0;
              tx_st_ff <= TX_DATA;
            end
          TX_DATA:
            if (bit_en)
            begin
              if (bit_ff == (seven_bit ? 3'h6 : 3'h7))
              begin
                line_ff  <= has_par ? par_ff : 1'b1;
                tx_st_ff <= has_par ? TX_PARITY : TX_STOP;
              end
              else
              begin
                line_ff  <= shreg_ff[0];
                shreg_ff <= {1'b0, shreg_ff[7:1]};
                bit_ff   <= bit_ff + 3'h1;
              end
            end
          TX_PARITY:
            if (bit_en)
            begin
              line_ff  <= 1'b1;
              tx_st_ff <= TX_STOP;
            end
          TX_STOP:
            if (bit_en)
              tx_st_ff <= TX_IDLE;
          default:
            tx_st_ff <= TX_IDLE;
        endcase
      end
    end

    assign grp_line[g] = line_ff;
    assign grp_busy[g] = active;
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  assign serial_out_one   = grp_line[0];
  assign serial_out_two   = grp_line[0];
  assign serial_out_three = grp_line[0];
  assign serial_out_four  = grp_line[1];
  assign serial_out_five  = grp_line[1];

endmodule
`default_nettype wire
